// ==== rtl/pqc_top.sv ====
// command interpreter: command words in, response words out
`timescale 1ns/1ps
`default_nettype none
module pqc_top (
    input wire logic clock, // 20 MHz clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic cmd_valid, // command half-word offered
    output logic cmd_ready, // interpreter takes half-word
    input wire logic [15:0] cmd_data, // command half-word, high first
    output logic rsp_valid, // response word offered
    input wire logic rsp_ready, // probe takes response
    output logic [31:0] rsp_data, // response word
    output logic mem_rd, // memory byte read strobe
    output logic [31:0] mem_addr, // memory byte address
    input wire logic [7:0] mem_rdata, // read byte, during mem_rd
    output logic mem_wr, // memory word write strobe
    output logic [31:0] mem_wdata, // word to write
    input wire logic mem_err, // write failed, with mem_wr
    output logic crc_method // 0 firmware, 1 hardware crc unit
);
    pqc_pkg::pqc_state_t state;
    logic [15:0] last_cmd;
    logic [2:0] arg_cnt;
    logic [2:0] arg_need;
    logic [127:0] args;
    logic [31:0] addr;
    logic [31:0] remain;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic rd_pend;
    logic [15:0] rc;
    logic [15:0] rsp_low;

    // half-words needed after the opcode
    function automatic logic [2:0] arg_len(input logic [15:0] op);
        case (op)
            pqc_pkg::OP_CRC: arg_len = 3'd4;
            pqc_pkg::OP_CLUSTER: arg_len = 3'd4;
            pqc_pkg::OP_OPTION: arg_len = 3'd2;
            default: arg_len = 3'd0;
        endcase
    endfunction : arg_len

    pqc_crc_byte u_crc (
        .crc_in(crc),
        .data(mem_rdata),
        .crc_out(next_crc)
    );

    ////////////////////////////////////////////////////////////////////
    // handshakes
    assign cmd_ready = (state == pqc_pkg::PQC_IDLE) ||
                       (state == pqc_pkg::PQC_ARG &&
                        arg_cnt != arg_need + 3'd1) ||
                       (state == pqc_pkg::PQC_WRITE && !mem_wr);
    assign rsp_valid = (state == pqc_pkg::PQC_RESP1) ||
                       (state == pqc_pkg::PQC_RESP2);

    ////////////////////////////////////////////////////////////////////
    // main sequencer
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= pqc_pkg::PQC_IDLE;
            last_cmd <= 16'h0000;
            arg_cnt <= 3'd0;
            arg_need <= 3'd0;
            args <= '0;
            addr <= 32'h00000000;
            remain <= 32'h00000000;
            crc <= pqc_pkg::CRC_SEED;
            rd_pend <= 1'b0;
            rc <= pqc_pkg::RC_PASS;
            rsp_low <= 16'h0000;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= 32'h00000000;
            crc_method <= 1'b0;
        end else begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            case (state)
                pqc_pkg::PQC_IDLE: begin
                    if (cmd_valid) begin
                        last_cmd <= cmd_data;
                        arg_cnt <= 3'd0;
                        arg_need <= arg_len(cmd_data);
                        state <= pqc_pkg::PQC_ARG;
                    end
                end
                pqc_pkg::PQC_ARG: begin
                    // low half of opcode word is disregarded
                    if (cmd_valid && arg_cnt != arg_need + 3'd1) begin
                        args <= {args[111:0], cmd_data};
                        arg_cnt <= arg_cnt + 3'd1;
                    end else if (arg_cnt == arg_need + 3'd1) begin
                        rc <= pqc_pkg::RC_PASS;
                        case (last_cmd)
                            pqc_pkg::OP_VERSION: begin
                                rsp_low <= pqc_pkg::AGENT_VERSION;
                                state <= pqc_pkg::PQC_RESP1;
                            end
                            pqc_pkg::OP_HWID: begin
                                rsp_low <= pqc_pkg::HW_ID;
                                state <= pqc_pkg::PQC_RESP1;
                            end
                            pqc_pkg::OP_OPTION: begin
                                crc_method <= args[0];
                                rsp_low <= pqc_pkg::RC_PASS;
                                state <= pqc_pkg::PQC_RESP1;
                            end
                            pqc_pkg::OP_CRC: begin
                                addr <= args[63:32];
                                remain <= args[31:0];
                                crc <= pqc_pkg::CRC_SEED;
                                rd_pend <= 1'b0;
                                state <= pqc_pkg::PQC_CRC;
                            end
                            pqc_pkg::OP_CLUSTER: begin
                                addr <= args[63:32];
                                remain <= args[31:0];
                                arg_cnt <= 3'd0; // data pairs counted afresh
                                // misaligned request refused
                                if (args[33:32] != 2'h0 ||
                                    (args[1:0] & pqc_pkg::WORD_ALIGN_MASK)
                                        != 2'h0) begin
                                    rsp_low <= pqc_pkg::RC_FAIL;
                                    state <= pqc_pkg::PQC_RESP1;
                                end else if (args[31:0] == 32'h0) begin
                                    rsp_low <= pqc_pkg::RC_PASS;
                                    state <= pqc_pkg::PQC_RESP1;
                                end else begin
                                    state <= pqc_pkg::PQC_WRITE;
                                end
                            end
                            default: begin
                                rsp_low <= pqc_pkg::RC_FAIL;
                                state <= pqc_pkg::PQC_RESP1;
                            end
                        endcase
                    end
                end
                pqc_pkg::PQC_CRC: begin
                    // one byte read and folded every two cycles
                    if (rd_pend) begin
                        crc <= next_crc;
                        rd_pend <= 1'b0;
                        addr <= addr + 32'h1;
                        remain <= remain - 32'h1;
                    end else if (remain != 32'h0) begin
                        mem_rd <= 1'b1;
                        rd_pend <= 1'b1;
                    end else begin
                        rsp_low <= pqc_pkg::RC_PASS;
                        state <= pqc_pkg::PQC_RESP1;
                    end
                end
                pqc_pkg::PQC_WRITE: begin
                    // data half-words high first, one word per write
                    if (cmd_valid && !mem_wr) begin
                        args <= {args[111:0], cmd_data};
                        arg_cnt <= arg_cnt + 3'd1;
                        if (arg_cnt[0]) begin
                            mem_wdata <= {args[15:0], cmd_data};
                            state <= pqc_pkg::PQC_MEMW;
                        end
                    end
                end
                pqc_pkg::PQC_MEMW: begin
                    mem_wr <= 1'b1;
                    // no half-word taken until the write completes
                    state <= pqc_pkg::PQC_WRITE;
                end
                pqc_pkg::PQC_RESP1: begin
                    if (rsp_ready) begin
                        if (last_cmd == pqc_pkg::OP_CRC) begin
                            state <= pqc_pkg::PQC_RESP2;
                        end else begin
                            state <= pqc_pkg::PQC_IDLE;
                        end
                    end
                end
                pqc_pkg::PQC_RESP2: begin
                    if (rsp_ready) begin
                        state <= pqc_pkg::PQC_IDLE;
                    end
                end
                default: state <= pqc_pkg::PQC_IDLE;
            endcase
            // write completion: advance or answer
            if (mem_wr) begin
                addr <= addr + pqc_pkg::BYTES_PER_WORD;
                remain <= remain - pqc_pkg::BYTES_PER_WORD;
                if (mem_err) begin
                    rsp_low <= pqc_pkg::RC_FAIL;
                    state <= pqc_pkg::PQC_RESP1;
                end else if (remain <= pqc_pkg::BYTES_PER_WORD) begin
                    rsp_low <= pqc_pkg::RC_PASS;
                    state <= pqc_pkg::PQC_RESP1;
                end else begin
                    state <= pqc_pkg::PQC_WRITE;
                end
            end
        end
    end

    assign mem_addr = addr;

    ////////////////////////////////////////////////////////////////////
    // response word: last command echoed in the upper half, zero upper half in the crc value word
    always_comb begin
        if (state == pqc_pkg::PQC_RESP2) begin
            rsp_data = {16'h0000, crc};
        end else begin
            rsp_data = {last_cmd, rsp_low};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_crc_done;
        state == pqc_pkg::PQC_RESP1 && last_cmd == pqc_pkg::OP_CRC &&
            rsp_ready;
    endsequence
    AST_CRC_TWO_WORDS: assert property (@(posedge clock) disable iff (!rstn)
        s_crc_done |=> state == pqc_pkg::PQC_RESP2)
        else $error("crc reply lacks second word");
    AST_ECHO: assert property (@(posedge clock) disable iff (!rstn)
        state == pqc_pkg::PQC_RESP1 |-> rsp_data[31:16] == last_cmd)
        else $error("response does not echo command");
    AST_VERSION: assert property (@(posedge clock) disable iff (!rstn)
        state == pqc_pkg::PQC_RESP1 && last_cmd == pqc_pkg::OP_VERSION
        |-> rsp_data[15:0] == pqc_pkg::AGENT_VERSION)
        else $error("wrong version value");
    AST_HWID: assert property (@(posedge clock) disable iff (!rstn)
        state == pqc_pkg::PQC_RESP1 && last_cmd == pqc_pkg::OP_HWID
        |-> rsp_data[15:0] == pqc_pkg::HW_ID)
        else $error("wrong hardware id");
    AST_CRC_HIGH: assert property (@(posedge clock) disable iff (!rstn)
        state == pqc_pkg::PQC_RESP2 |-> rsp_data[31:16] == 16'h0000)
        else $error("crc upper half not zero");
    AST_FOLD: assert property (@(posedge clock) disable iff (!rstn)
        mem_rd |-> rd_pend ##1 crc == $past(next_crc))
        else $error("crc byte not folded");
    AST_OPTION: assert property (@(posedge clock) disable iff (!rstn)
        state == pqc_pkg::PQC_RESP1 && last_cmd == pqc_pkg::OP_OPTION
        |-> crc_method == args[0])
        else $error("crc method not taken from flag");
    AST_UNKNOWN: assert property (@(posedge clock) disable iff (!rstn)
        state == pqc_pkg::PQC_RESP1 && arg_need == 3'd0 &&
        last_cmd != pqc_pkg::OP_VERSION && last_cmd != pqc_pkg::OP_HWID
        |-> rsp_low == pqc_pkg::RC_FAIL)
        else $error("unknown opcode not failed");
    AST_WR_STEP: assert property (@(posedge clock) disable iff (!rstn)
        mem_wr |=> addr == $past(addr) + pqc_pkg::BYTES_PER_WORD)
        else $error("write address not advanced");
endmodule : pqc_top
`default_nettype wire

// ==== rtl/pqc_pkg.sv ====
// package of constants for the programming agent command interpreter
// Function
// - version query opcode 7 returns agent version
// - version reply: last command high, version low
// - crc query opcode 8, address, byte length
// - crc ccitt poly 1021, seed FFFF, msb first
// - crc reply two words, crc low valid
// - cluster write stores 32-bit words, replies return code
// - hardware id query opcode A returns identifier
// - option flag 0 firmware, 1 hardware crc
// - option command: opcode, flag high, low halves
package pqc_pkg;
    localparam logic [15:0] OP_VERSION = 16'h0007;
    localparam logic [15:0] OP_CRC = 16'h0008;
    localparam logic [15:0] OP_CLUSTER = 16'h0009;
    localparam logic [15:0] OP_HWID = 16'h000A;
    localparam logic [15:0] OP_OPTION = 16'h000B;
    localparam logic [15:0] RC_PASS = 16'h0000;
    localparam logic [15:0] RC_FAIL = 16'h0003;
    // arbitrary values, not tied to any part
    localparam logic [15:0] AGENT_VERSION = 16'h0042;
    localparam logic [15:0] HW_ID = 16'h1234;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_SEED = 16'hFFFF;
    localparam logic [1:0] WORD_ALIGN_MASK = 2'h3;
    localparam logic [31:0] BYTES_PER_WORD = 32'h00000004;
    typedef enum logic [6:0] {
        PQC_IDLE = 7'b0000001,
        PQC_ARG = 7'b0000010,
        PQC_CRC = 7'b0000100,
        PQC_WRITE = 7'b0001000,
        PQC_RESP1 = 7'b0010000,
        PQC_RESP2 = 7'b0100000,
        PQC_MEMW = 7'b1000000
    } pqc_state_t;
endpackage : pqc_pkg

// ==== rtl/pqc_crc_byte.sv ====
// one-byte crc-ccitt update step
`timescale 1ns/1ps
`default_nettype none
module pqc_crc_byte (
    input wire logic [15:0] crc_in, // running crc
    input wire logic [7:0] data, // byte entering msb first
    output logic [15:0] crc_out // updated crc
);
    // eight shift steps of the polynomial, msb first
    always_comb begin
        logic [15:0] c;
        c = crc_in;
        for (int i = 7; i >= 0; i--) begin
            if (c[15] ^ data[i]) begin
                c = {c[14:0], 1'b0} ^ pqc_pkg::CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        crc_out = c;
    end
endmodule : pqc_crc_byte
`default_nettype wire

// ==== test/pqc_mem_model.sv ====
// memory partner model: byte reads and word writes
`timescale 1ns/1ps
`default_nettype none
module pqc_mem_model (
    input wire logic clock, // system clock
    input wire logic mem_rd, // byte read strobe
    input wire logic [31:0] mem_addr, // byte or word address
    output logic [7:0] mem_rdata, // byte, while strobe is high
    input wire logic mem_wr, // word write strobe
    input wire logic [31:0] mem_wdata, // word to store
    output logic mem_err, // write failure flag
    input wire logic fail_wr // bench asks for failing writes
);
    logic [31:0] words [16];
    ////////////////////////////////////////////////////////////////////////
    // byte pattern from address, inverted when not strobed
    assign mem_rdata = (mem_addr[7:0] ^ 8'hA5) ^ {8{~mem_rd}};
    // store written words by word index
    always_ff @(posedge clock) begin
        if (mem_wr) begin
            words[mem_addr[5:2]] <= mem_wdata;
        end
    end
    // failure only alongside the write strobe
    assign mem_err = mem_wr & fail_wr;
endmodule : pqc_mem_model
`default_nettype wire

// ==== test/test_prog_exec_query_commands.sv ====
// self-checking bench of the command interpreter
`timescale 1ns/1ps
`default_nettype none
module test_prog_exec_query_commands;
    typedef struct {
        logic [3:0][15:0] h;
        int n;
        logic [31:0] rsp;
        logic meth;
    } pqc_row_t;
    logic clock, rstn, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
    logic [15:0] cmd_data;
    logic [31:0] rsp_data, mem_addr, mem_wdata, w;
    logic mem_rd, mem_wr, mem_err, crc_method, fail_wr;
    logic [7:0] mem_rdata;
    int error_cnt, n_checks;
    pqc_row_t rows [6] = '{
        '{{16'h0007, 16'hFFFF, 16'h0, 16'h0}, 2, 32'h00070042, 1'b0},
        '{{16'h000A, 16'h0000, 16'h0, 16'h0}, 2, 32'h000A1234, 1'b0},
        '{{16'h000B, 16'h0000, 16'h0000, 16'h0001}, 4, 32'h000B0000, 1'b1},
        '{{16'h000B, 16'h0000, 16'h0000, 16'h0000}, 4, 32'h000B0000, 1'b0},
        '{{16'h0005, 16'h0000, 16'h0, 16'h0}, 2, 32'h00050003, 1'b0},
        '{{16'h000C, 16'h1234, 16'h0, 16'h0}, 2, 32'h000C0003, 1'b0}};
    pqc_top dut (.clock(clock), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_data(rsp_data), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_err(mem_err), .crc_method(crc_method));
    pqc_mem_model u_mem (.clock(clock), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_err(mem_err), .fail_wr(fail_wr));
    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task summarize;
        $display("errors %0d checks %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    // compare one value
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // offer n half-words, highest first, each held until taken
    task send(input logic [63:0] hw, input int n);
        int t;
        logic rdy;
        @(posedge clock);
        for (int i = 0; i < n; i++) begin
            cmd_valid <= 1'b1;
            cmd_data <= hw[63-16*i -: 16];
            t = 0;
            // ready looked at where settled, before the edge
            do begin
                @(negedge clock);
                rdy = cmd_ready;
                @(posedge clock);
                t++;
            end while (rdy !== 1'b1 && t < 500);
            if (t >= 500) begin
                error_cnt++;
                summarize();
            end
        end
        cmd_valid <= 1'b0;
    endtask : send
    // take one response word at the edge it is accepted
    task rcv(output logic [31:0] d);
        int t;
        logic acc;
        t = 0;
        do begin
            @(negedge clock);
            acc = rsp_valid === 1'b1 && rsp_ready === 1'b1;
            d = rsp_data;
            @(posedge clock);
            t++;
        end while (!acc && t < 500);
        if (t >= 500) begin
            error_cnt++;
            summarize();
        end
    endtask : rcv
    // crc over len bytes from addr
    task crc_case(input logic [15:0] addr, input logic [15:0] len);
        logic [15:0] c;
        logic [7:0] b;
        c = 16'hFFFF;
        for (int a = 0; a < len; a++) begin
            b = (addr[7:0] + a[7:0]) ^ 8'hA5;
            for (int k = 7; k >= 0; k--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? 16'h1021 : 16'h0000);
            end
        end
        send({16'h0008, 16'h0000, 16'h0000, addr}, 4);
        send({16'h0000, len, 32'h0}, 2);
        rcv(w);
        chk("crc status", w, 32'h00080000);
        rcv(w);
        chk("crc value", w, {16'h0000, c});
    endtask : crc_case
    ////////////////////////////////////////////////////////////////////////
    // clock of 50 ns
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // main sequence
    initial begin
        {rstn, cmd_valid, fail_wr, cmd_data} = '0;
        rsp_ready = 1'b1;
        error_cnt = 0;
        n_checks = 0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        chk("reset outs", {rsp_valid, cmd_ready, crc_method}, 3'b010);
        foreach (rows[i]) begin
            send(rows[i].h, rows[i].n);
            rcv(w);
            chk("response", w, rows[i].rsp);
            @(negedge clock);
            chk("method", crc_method, rows[i].meth);
        end
        crc_case(16'h0010, 16'h0005);
        crc_case(16'h0003, 16'h0000);
        // cluster of two words, probe keeps alignment
        send({16'h0009, 16'h0000, 16'h0000, 16'h0020}, 4);
        send({16'h0000, 16'h0008, 32'hCAFE1357}, 4);
        send({32'h2468ACE0, 32'h0}, 2);
        rcv(w);
        chk("cluster ok", w, 32'h00090000);
        chk("word 0", u_mem.words[8], 32'hCAFE1357);
        chk("word 1", u_mem.words[9], 32'h2468ACE0);
        // misaligned start refused at once
        send({16'h0009, 16'h0000, 16'h0000, 16'h0022}, 4);
        send({16'h0000, 16'h0008, 32'h0}, 2);
        rcv(w);
        chk("misaligned", w, 32'h00090003);
        // empty cluster answers pass at once
        send({16'h0009, 16'h0000, 16'h0000, 16'h0040}, 4);
        send({16'h0000, 16'h0000, 32'h0}, 2);
        rcv(w);
        chk("empty cluster", w, 32'h00090000);
        // failing write stops the cluster after one word
        fail_wr <= 1'b1;
        send({16'h0009, 16'h0000, 16'h0000, 16'h0030}, 4);
        send({16'h0000, 16'h0008, 32'h11112222}, 4);
        rcv(w);
        chk("write fail", w, 32'h00090003);
        chk("fail row", u_mem.words[12], 32'h11112222);
        fail_wr <= 1'b0;
        // response held while the probe stalls
        rsp_ready <= 1'b0;
        send({16'h0007, 16'h0000, 32'h0}, 2);
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk("held valid", {rsp_valid, cmd_ready}, 2'b10);
        chk("held data", rsp_data, 32'h00070042);
        @(posedge clock);
        rsp_ready <= 1'b1;
        rcv(w);
        chk("after stall", w, 32'h00070042);
        // second reset clears the method choice
        send(rows[2].h, 4);
        rcv(w);
        chk("method set", crc_method, 1'b1);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        chk("reset method", {rsp_valid, cmd_ready, crc_method}, 3'b010);
        summarize();
    end
endmodule : test_prog_exec_query_commands
`default_nettype wire
